// File: core/srtc_pkg.sv
// shared constants for the serial calendar clock core
package srtc_pkg;
   localparam logic [4:0] REG_SEC      = 5'h00;
   localparam logic [4:0] REG_MIN      = 5'h01;
   localparam logic [4:0] REG_HOUR     = 5'h02;
   localparam logic [4:0] REG_DAY      = 5'h03;
   localparam logic [4:0] REG_DATE     = 5'h04;
   localparam logic [4:0] REG_MONTH    = 5'h05;
   localparam logic [4:0] REG_YEAR     = 5'h06;
   localparam logic [4:0] REG_CTRL     = 5'h0e;
   localparam logic [4:0] REG_LAST     = 5'h10;
   localparam int         NUM_REGS     = 17;
   localparam int         NUM_TIME     = 7;
   localparam logic [6:0] DEV_ADDR     = 7'h68;
   localparam int         HOUR_12_BIT  = 6;
   localparam int         HOUR_PM_BIT  = 5;
   localparam int         CENTURY_BIT  = 7;
   localparam int         CTRL_OSC_OFF = 7;
   localparam int         CTRL_INTCN   = 2;
   localparam int         CTRL_SQW_EN  = 4;
   localparam logic [7:0] CTRL_RESET   = 8'h18;
   localparam int         OSC_HZ       = 32768;
   localparam int         OSC_HALF     = OSC_HZ / 2;
   localparam logic [7:0] DATE_RESET   = 8'h01;
   localparam logic [7:0] MONTH_RESET  = 8'h01;
   localparam logic [7:0] DAY_RESET    = 8'h01;
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RACK, ST_SKIP} srtc_state_t;
endpackage

// File: core/srtc_core.sv
// calendar core with two-wire slave register access
// Behaviour
// - calendar seconds to year, leap through 2099
// - month end rolls date for short months
// - hours in 24-hour or 12-hour with pm
// - access opens with start and address, slave only
// - successive registers per byte until stop
// - power fail blocks address ack and writes, not reads already acked
// - data line only pulled low or released
// - one open-drain wave output, released in interrupt mode
// - time base from gated 32.768kHz oscillator
// - pointer wraps past 10h to 00h
// - snapshot on start, stop, wrap to 00h
// - time register reads served from the snapshot copy
// - time registers held in bcd
// - written byte stored at acknowledge
`timescale 1ns/1ps
module srtc_core
   import srtc_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_oe,
   output logic      sda_out,
   input  wire logic osc_input_pin,
   input  wire logic power_fail_threshold,
   output logic      wave_or_irq_out_oe,
   output logic      wave_or_irq_out
);
   import srtc_pkg::*;

   logic [7:0]  regs_reg [NUM_REGS];
   logic [7:0]  regs_next [NUM_REGS];
   logic [7:0]  snap_reg [NUM_TIME];
   logic [7:0]  snap_next [NUM_TIME];
   logic [2:0]  scl_s_reg, sda_s_reg, osc_s_reg, pf_s_reg;
   srtc_state_t st_reg, st_next;
   logic [3:0]  bit_reg, bit_next;
   logic [7:0]  sh_reg, sh_next;
   logic [4:0]  ptr_reg, ptr_next;
   logic        first_reg, first_next;
   logic        sda_oe_reg, sda_oe_next;
   logic [14:0] div_reg, div_next;
   logic        irq_oe_reg, irq_oe_next;
   logic        rmode_reg, rmode_next;

   // bcd increment with wrap to a floor value
   function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top, input logic [7:0] floor);
      if (v >= top)
         return floor;
      else if (v[3:0] == 4'h9)
         return {v[7:4] + 4'h1, 4'h0};
      else
         return {v[7:4], v[3:0] + 4'h1};
   endfunction

   // last date of a month, bcd
   function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
      unique case (mon)
         8'h02:                         return leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11:    return 8'h30;
         default:                       return 8'h31;
      endcase
   endfunction

   // pointer step with wrap
   function automatic logic [4:0] ptr_inc(input logic [4:0] p);
      return (p >= REG_LAST) ? 5'h00 : p + 5'h01;
   endfunction

   wire scl    = scl_s_reg[1];
   wire sda    = sda_s_reg[1];
   wire scl_r  = scl_s_reg[1] & ~scl_s_reg[2];
   wire scl_f  = ~scl_s_reg[1] & scl_s_reg[2];
   wire start  = scl & scl_s_reg[2] & ~sda_s_reg[1] & sda_s_reg[2];
   wire stop   = scl & scl_s_reg[2] & sda_s_reg[1] & ~sda_s_reg[2];
   wire osc_r  = osc_s_reg[1] & ~osc_s_reg[2];
   wire blocked = pf_s_reg[1];

   always_ff @(posedge mclk) begin
      if (rst) begin
         scl_s_reg <= 3'h7;
         sda_s_reg <= 3'h7;
         osc_s_reg <= 3'h0;
         pf_s_reg  <= 3'h0;
      end else begin
         scl_s_reg <= {scl_s_reg[1:0], scl_in};
         sda_s_reg <= {sda_s_reg[1:0], sda_in};
         osc_s_reg <= {osc_s_reg[1:0], osc_input_pin};
         pf_s_reg  <= {pf_s_reg[1:0], power_fail_threshold};
      end
   end

   always_comb begin
      logic       tick;
      logic       roll;
      logic [7:0] h;
      logic       wr_now;
      logic       snap_now;
      logic [7:0] rd;
      logic [7:0] inc_v;
      tick     = 1'b0;
      inc_v    = 8'h00;
      roll     = 1'b0;
      h        = 8'h00;
      wr_now   = 1'b0;
      snap_now = 1'b0;
      rd       = 8'h00;
      for (int i = 0; i < NUM_REGS; i++)
         regs_next[i] = regs_reg[i];
      for (int i = 0; i < NUM_TIME; i++)
         snap_next[i] = snap_reg[i];
      st_next     = st_reg;
      bit_next    = bit_reg;
      sh_next     = sh_reg;
      ptr_next    = ptr_reg;
      first_next  = first_reg;
      sda_oe_next = sda_oe_reg;
      div_next    = div_reg;
      rmode_next  = rmode_reg;

      if (!regs_reg[REG_CTRL][CTRL_OSC_OFF] && osc_r) begin
         if (div_reg == 15'(OSC_HZ - 1)) begin
            div_next = 15'h0000;
            tick     = 1'b1;
         end else begin
            div_next = div_reg + 15'h0001;
         end
      end

      if (tick) begin
         regs_next[REG_SEC] = bcd_inc(regs_reg[REG_SEC], 8'h59, 8'h00);
         if (regs_reg[REG_SEC] == 8'h59) begin
            regs_next[REG_MIN] = bcd_inc(regs_reg[REG_MIN], 8'h59, 8'h00);
            if (regs_reg[REG_MIN] == 8'h59) begin
               h = regs_reg[REG_HOUR];
               if (h[HOUR_12_BIT]) begin
                  if (h[4:0] == 5'h11) begin
                     regs_next[REG_HOUR] = {h[7:6], ~h[HOUR_PM_BIT], 5'h12};
                     roll = h[HOUR_PM_BIT];
                  end else begin
                     inc_v               = bcd_inc({3'h0, h[4:0]}, 8'h12, 8'h01);
                     regs_next[REG_HOUR] = {h[7:5], inc_v[4:0]};
                  end
               end else begin
                  inc_v               = bcd_inc({2'h0, h[5:0]}, 8'h23, 8'h00);
                  regs_next[REG_HOUR] = {2'h0, inc_v[5:0]};
                  roll = (h[5:0] == 6'h23);
               end
               if (roll) begin
                  regs_next[REG_DAY] = bcd_inc(regs_reg[REG_DAY], 8'h07, 8'h01);
                  regs_next[REG_DATE] = bcd_inc(regs_reg[REG_DATE],
                     month_end(regs_reg[REG_MONTH] & 8'h1f, regs_reg[REG_YEAR]), 8'h01);
                  if (regs_reg[REG_DATE] >= month_end(regs_reg[REG_MONTH] & 8'h1f, regs_reg[REG_YEAR])) begin
                     inc_v                = bcd_inc(regs_reg[REG_MONTH] & 8'h1f, 8'h12, 8'h01);
                     regs_next[REG_MONTH] = {regs_reg[REG_MONTH][7], inc_v[6:0]};
                     if ((regs_reg[REG_MONTH] & 8'h1f) == 8'h12) begin
                        regs_next[REG_YEAR] = bcd_inc(regs_reg[REG_YEAR], 8'h99, 8'h00);
                        if (regs_reg[REG_YEAR] == 8'h99)
                           regs_next[REG_MONTH][CENTURY_BIT] = ~regs_reg[REG_MONTH][CENTURY_BIT];
                     end
                  end
               end
            end
         end
      end

      // unused pointer values read as zero
      if (ptr_reg > REG_LAST)
         rd = 8'h00;
      else if (ptr_reg < 5'(NUM_TIME))
         rd = snap_reg[ptr_reg[2:0]];
      else
         rd = regs_reg[ptr_reg];

      if (start) begin
         st_next     = ST_ADDR;
         bit_next    = 4'h0;
         first_next  = 1'b1;
         rmode_next  = 1'b0;
         sda_oe_next = 1'b0;
         snap_now    = 1'b1;
      end else if (stop) begin
         st_next     = ST_IDLE;
         sda_oe_next = 1'b0;
         snap_now    = 1'b1;
      end else begin
         unique case (st_reg)
            ST_IDLE, ST_SKIP: ;
            ST_ADDR, ST_WDATA: begin
               if (scl_r) begin
                  sh_next  = {sh_reg[6:0], sda};
                  bit_next = bit_reg + 4'h1;
               end
               if (scl_f && bit_reg == 4'h8) begin
                  bit_next = 4'h0;
                  if (st_reg == ST_ADDR) begin
                     if (sh_reg[7:1] == DEV_ADDR && !blocked) begin
                        sda_oe_next = 1'b1;
                        st_next     = ST_ACK;
                        first_next  = ~sh_reg[0];
                        rmode_next  = sh_reg[0];
                     end else
                        st_next = ST_SKIP;
                  end else if (!blocked) begin
                     sda_oe_next = 1'b1;
                     st_next     = ST_ACK;
                     wr_now      = 1'b1;
                  end else
                     st_next = ST_SKIP;
               end
            end
            ST_ACK: begin
               if (scl_f) begin
                  sda_oe_next = 1'b0;
                  // read direction only after the address byte
                  if (rmode_reg) begin
                     st_next     = ST_RDATA;
                     sh_next     = rd;
                     sda_oe_next = ~rd[7];
                     bit_next    = 4'h1;
                  end else
                     st_next = ST_WDATA;
               end
            end
            ST_RDATA: begin
               if (scl_f) begin
                  if (bit_reg == 4'h8) begin
                     sda_oe_next = 1'b0;
                     st_next     = ST_RACK;
                     ptr_next    = ptr_inc(ptr_reg);
                     snap_now    = (ptr_inc(ptr_reg) == 5'h00);
                  end else begin
                     sh_next     = {sh_reg[6:0], 1'b0};
                     sda_oe_next = ~sh_reg[6];
                     bit_next    = bit_reg + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_r && sda)
                  st_next = ST_SKIP;
               else if (scl_f) begin
                  sh_next     = rd;
                  sda_oe_next = ~rd[7];
                  bit_next    = 4'h1;
                  st_next     = ST_RDATA;
               end
            end
            default: st_next = ST_IDLE;
         endcase
      end

      if (wr_now) begin
         if (first_reg) begin
            ptr_next   = sh_reg[4:0];
            first_next = 1'b0;
         end else begin
            if (ptr_reg <= REG_LAST)
               regs_next[ptr_reg] = sh_reg;
            if (ptr_reg == REG_SEC)
               div_next = 15'h0000;
            ptr_next = ptr_inc(ptr_reg);
            snap_now = (ptr_inc(ptr_reg) == 5'h00);
         end
      end

      if (snap_now)
         for (int i = 0; i < NUM_TIME; i++)
            snap_next[i] = regs_next[i];

      irq_oe_next = regs_reg[REG_CTRL][CTRL_INTCN] ? 1'b0
                  : (regs_reg[REG_CTRL][CTRL_SQW_EN] && !regs_reg[REG_CTRL][CTRL_OSC_OFF]
                     && div_reg < 15'(OSC_HALF));
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++)
            regs_reg[i] <= 8'h00;
         regs_reg[REG_DAY]   <= DAY_RESET;
         regs_reg[REG_DATE]  <= DATE_RESET;
         regs_reg[REG_MONTH] <= MONTH_RESET;
         regs_reg[REG_CTRL]  <= CTRL_RESET;
         for (int i = 0; i < NUM_TIME; i++)
            snap_reg[i] <= 8'h00;
         st_reg     <= ST_IDLE;
         bit_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         ptr_reg    <= 5'h00;
         first_reg  <= 1'b0;
         sda_oe_reg <= 1'b0;
         div_reg    <= 15'h0000;
         irq_oe_reg <= 1'b0;
         rmode_reg  <= 1'b0;
      end else begin
         regs_reg   <= regs_next;
         snap_reg   <= snap_next;
         st_reg     <= st_next;
         bit_reg    <= bit_next;
         sh_reg     <= sh_next;
         ptr_reg    <= ptr_next;
         first_reg  <= first_next;
         sda_oe_reg <= sda_oe_next;
         div_reg    <= div_next;
         irq_oe_reg <= irq_oe_next;
         rmode_reg  <= rmode_next;
      end
   end

   // open drain, only low when enabled
   always_ff @(posedge mclk) begin
      if (rst) begin
         sda_out         <= 1'b0;
         wave_or_irq_out <= 1'b0;
      end else begin
         sda_out         <= 1'b0;
         wave_or_irq_out <= 1'b0;
      end
   end
   assign sda_oe             = sda_oe_reg;
   assign wave_or_irq_out_oe = irq_oe_reg;
endmodule

// File: verif/srtc_core_properties.sv
// pin-level assertions for the calendar core
`timescale 1ns/1ps
module srtc_core_properties (
   input wire logic mclk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic sda_out,
   input wire logic osc_input_pin,
   input wire logic power_fail_threshold,
   input wire logic wave_or_irq_out_oe,
   input wire logic wave_or_irq_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic [7:0] run_reg;
   logic [7:0] run_next;
   always_comb run_next = sda_oe ? run_reg + 8'h01 : 8'h00;
   always_ff @(posedge mclk) run_reg <= rst ? 8'h00 : run_next;
   a_sda_never_high: assert property (sda_out == 1'b0) else $error("data pin driven high");
   a_wave_never_high: assert property (wave_or_irq_out == 1'b0) else $error("wave pin driven high");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sda_oe && !wave_or_irq_out_oe)
      else $error("outputs active after reset");
   a_pfail_no_ack: assert property (power_fail_threshold [*4] |-> !sda_oe) else $error("access during power fail");
   a_oe_run_bound: assert property (run_reg <= 8'd80) else $error("data pin held low too long");
   a_stop_release: assert property (scl_in && $rose(sda_in) |-> ##[1:6] !sda_oe) else $error("pin held after stop");
   a_start_listen: assert property (scl_in && $fell(sda_in) |=> !sda_oe [*8]) else $error("driven during address");
   a_wave_idle_hold: assert property (($stable(osc_input_pin) && scl_in) [*6] |-> $stable(wave_or_irq_out_oe))
      else $error("wave pin moved without time base");
   c_ack: cover property ($rose(sda_oe));
   c_wave_half: cover property ($fell(wave_or_irq_out_oe));
   c_pfail_start: cover property (power_fail_threshold && scl_in && $fell(sda_in));
endmodule
bind srtc_core srtc_core_properties chk (.mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_oe(sda_oe), .sda_out(sda_out), .osc_input_pin(osc_input_pin),
   .power_fail_threshold(power_fail_threshold), .wave_or_irq_out_oe(wave_or_irq_out_oe),
   .wave_or_irq_out(wave_or_irq_out));

// File: verif/srtc_bus_master.sv
// two-wire bus master model facing the calendar core
`timescale 1ns/1ps
module srtc_bus_master (
   input  wire logic mclk,
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic q(input int n);
      repeat (2 * n) @(negedge mclk);
   endtask
   task automatic start();
      sda_pull = 1'b1;
      q(1);
      scl = 1'b0;
   endtask
   task automatic stop();
      q(1);
      sda_pull = 1'b1;
      q(1);
      scl = 1'b1;
      q(1);
      sda_pull = 1'b0;
      q(2);
   endtask
   // sample just before the falling clock edge
   task automatic bit_io(input logic b, output logic s);
      q(1);
      sda_pull = !b;
      q(1);
      scl = 1'b1;
      q(2);
      s = sda_wire;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] w, input logic ack_in, output logic [7:0] r, output logic ack_seen);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(!ack_in, a);
      ack_seen = !a;
   endtask
endmodule

// File: verif/srtc_core_bench.sv
// self-checking bench for the calendar core
`timescale 1ns/1ps
module srtc_core_bench;
   import srtc_pkg::*;
   logic mclk, rst, osc, pfail, scl, pull, sda_oe, sda_out, w_oe, w_out;
   int   err_count, checks_done;
   wire  sda = !(pull || (sda_oe && !sda_out));
   srtc_core DUT (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_oe(sda_oe), .sda_out(sda_out),
      .osc_input_pin(osc), .power_fail_threshold(pfail), .wave_or_irq_out_oe(w_oe), .wave_or_irq_out(w_out));
   srtc_bus_master host (.mclk(mclk), .scl(scl), .sda_pull(pull), .sda_wire(sda));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   // first byte is the pointer
   task automatic wr(input logic [7:0] d[$]);
      logic [7:0] r;
      logic a;
      host.start();
      host.xfer({DEV_ADDR, 1'b0}, 1'b0, r, a);
      chk("write address ack", 8'h01, {7'h00, a});
      foreach (d[i]) begin
         host.xfer(d[i], 1'b0, r, a);
         chk("write byte ack", 8'h01, {7'h00, a});
      end
      host.stop();
   endtask
   task automatic rd(input logic [7:0] e[$]);
      logic [7:0] r;
      logic a;
      host.start();
      host.xfer({DEV_ADDR, 1'b1}, 1'b0, r, a);
      chk("read address ack", 8'h01, {7'h00, a});
      foreach (e[i]) begin
         host.xfer(8'hff, i < e.size() - 1, r, a);
         chk("read byte", e[i], r);
      end
      host.stop();
   endtask
   task automatic osc_run(input int n);
      repeat (2 * n) @(negedge mclk) osc = !osc;
   endtask
   task automatic t_reset_read();
      rd('{8'h00, 8'h00, 8'h00, DAY_RESET, DATE_RESET, MONTH_RESET, 8'h00});
   endtask
   task automatic t_wrap();
      wr('{8'h10, 8'h77, 8'h30});
      wr('{8'h10});
      rd('{8'h77, 8'h30, 8'h00});
   endtask
   task automatic t_refused();
      logic [7:0] r;
      logic a;
      host.start();
      host.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, r, a);
      chk("foreign address ack", 8'h00, {7'h00, a});
      host.stop();
      pfail = 1'b1;
      host.start();
      host.xfer({DEV_ADDR, 1'b1}, 1'b0, r, a);
      chk("power fail ack", 8'h00, {7'h00, a});
      host.stop();
      pfail = 1'b0;
      rd('{8'h00});
   endtask
   task automatic t_calendar();
      wr('{8'h00, 8'h59, 8'h59, 8'h71, 8'h03, 8'h28, 8'h02, 8'h24});
      repeat (8) @(negedge mclk);
      chk("wave first half", 8'h01, {7'h00, w_oe});
      // stopped oscillator must not advance the divider
      wr('{{3'h0, REG_CTRL}, 8'h98});
      repeat (8) @(negedge mclk);
      chk("wave with oscillator off", 8'h00, {7'h00, w_oe});
      osc_run(100);
      wr('{{3'h0, REG_CTRL}, CTRL_RESET});
      osc_run(16300);
      chk("wave late first half", 8'h01, {7'h00, w_oe});
      osc_run(100);
      chk("wave second half", 8'h00, {7'h00, w_oe});
      osc_run(16400);
      wr('{8'h00});
      rd('{8'h00, 8'h00, 8'h52, 8'h04, 8'h29, 8'h02, 8'h24});
   endtask
   task automatic t_irq_mode();
      chk("wave before mode change", 8'h01, {7'h00, w_oe});
      wr('{{3'h0, REG_CTRL}, 8'h1c});
      repeat (8) @(negedge mclk);
      chk("pin in interrupt mode", 8'h00, {7'h00, w_oe});
   endtask
   initial begin
      repeat (100000) @(posedge mclk);
      err_count++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      osc = 1'b0;
      pfail = 1'b0;
      err_count = 0;
      checks_done = 0;
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst = 1'b0;
      repeat (6) @(negedge mclk);
      t_reset_read();
      t_wrap();
      t_refused();
      t_calendar();
      t_irq_mode();
      end_of_test();
   end
endmodule
